/* File: etc_pkg.sv */
// Constants, field layout and types of the enhanced timer compare unit.
// Assumes a 32-bit APB slave with byte addresses, one register per word.
package etc_pkg;

  // Counter width and the width of the coarse period field
  localparam int unsigned CNT_W = 10;
  localparam int unsigned PER_W = 3;
  localparam int unsigned ADDR_W = 8;

  // Timer clock divider: default counts on every fourth system clock
  localparam int unsigned TICK_DIV = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CHA = 8'h04;
  localparam logic [7:0] OFF_CHB = 8'h08;
  localparam logic [7:0] OFF_CNT_LO = 8'h0c;
  localparam logic [7:0] OFF_CNT_HI = 8'h10;
  localparam logic [7:0] OFF_CMPA_LO = 8'h14;
  localparam logic [7:0] OFF_CMPA_HI = 8'h18;
  localparam logic [7:0] OFF_CMPB_LO = 8'h1c;
  localparam logic [7:0] OFF_CMPB_HI = 8'h20;
  localparam logic [7:0] OFF_FLAGS = 8'h24;

  // Field positions in the timer control word
  localparam int unsigned CTRL0_PAUSE = 7;
  localparam int unsigned CTRL0_ON = 3;
  localparam int unsigned CTRL0_PER_LSB = 0;
  // Field positions shared by both channel control words
  localparam int unsigned CH_MODE_LSB = 6;
  localparam int unsigned CH_FN_LSB = 4;
  localparam int unsigned CH_INIT = 3;
  localparam int unsigned CH_INV = 2;
  // Channel A only: count direction (read only) and clear source
  localparam int unsigned CHA_DIR = 1;
  localparam int unsigned CHA_CLR = 0;
  // Channel B only: PWM alignment
  localparam int unsigned CHB_ALIGN_LSB = 0;
  // Flag register bits
  localparam int unsigned FLAG_A = 0;
  localparam int unsigned FLAG_B = 1;
  localparam int unsigned FLAG_P = 2;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] CMP_RST = 10'h000;

  // Channel operating modes
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } etc_mode_type;

  // Pin-function codes, read per mode
  localparam logic [1:0] FN_HOLD = 2'b00;
  localparam logic [1:0] FN_LOW = 2'b01;
  localparam logic [1:0] FN_HIGH = 2'b10;
  localparam logic [1:0] FN_TOGGLE = 2'b11;
  localparam logic [1:0] FN_INACT = 2'b00;
  localparam logic [1:0] FN_ACT = 2'b01;
  localparam logic [1:0] FN_PWM = 2'b10;
  localparam logic [1:0] FN_PULSE = 2'b11;
  localparam logic [1:0] CAP_RISE = 2'b00;
  localparam logic [1:0] CAP_FALL = 2'b01;
  localparam logic [1:0] CAP_BOTH = 2'b10;
  localparam logic [1:0] CAP_OFF = 2'b11;

  // PWM alignment codes
  localparam logic [1:0] ALIGN_EDGE = 2'b00;
  localparam logic [1:0] ALIGN_UP = 2'b01;
  localparam logic [1:0] ALIGN_DN = 2'b10;
  localparam logic [1:0] ALIGN_BOTH = 2'b11;

  // Count direction
  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } etc_dir_type;

  // Split a 10-bit value into its low byte, zero-extended to a bus word
  function automatic logic [31:0] etc_lo_word(input logic [9:0] v);
    etc_lo_word = {24'h000000, v[7:0]};
  endfunction : etc_lo_word

  // High bits of a 10-bit value; unimplemented bits read zero
  function automatic logic [31:0] etc_hi_word(input logic [9:0] v);
    etc_hi_word = {30'h00000000, v[9:8]};
  endfunction : etc_hi_word

endpackage : etc_pkg

/* File: etc_chan_out.sv */
// One output channel: compare, PWM, single pulse and capture edge logic.
// Assumes hit pulses and counter come from the timer core on ref_clk.
`timescale 1ns/1ps
module etc_chan_out (
  input wire logic ref_clk,
  input wire logic rstn,
  input etc_pkg::etc_mode_type mode,
  input wire logic [1:0] pin_fn,
  input wire logic init_lvl,
  input wire logic invert,
  input wire logic on_rise,
  input wire logic on_now,
  input wire logic hit,
  input wire logic [9:0] cnt,
  input wire logic [9:0] cmp,
  input wire logic cap_in,
  output logic cap_evt,
  output logic pin_q,
  output logic pin_oe_q
);
  import etc_pkg::*;

  logic lvl_q; // Compare-mode pin level before inversion
  logic moved_q; // A compare-mode match has come since the start
  logic pulse_q; // Single pulse in its active state
  logic cap_prev_q; // Capture input one clock ago
  logic raw; // Pin level before inversion

  // Compare-mode level; follows the initial level until a match moves it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lvl_q <= 1'b0;
      moved_q <= 1'b0;
    end else if (on_rise) begin
      lvl_q <= init_lvl; // R8
      moved_q <= 1'b0;
    end else if (mode == MODE_CMP && hit) begin
      moved_q <= 1'b1;
      unique case (pin_fn) // R3
        FN_HOLD: lvl_q <= lvl_q;
        FN_LOW: lvl_q <= 1'b0; // R7
        FN_HIGH: lvl_q <= 1'b1; // R7
        FN_TOGGLE: lvl_q <= ~lvl_q;
      endcase
    end else if (!moved_q) begin
      lvl_q <= init_lvl; // R6
    end
  end

  // Single pulse starts with the timer and ends on a match or on switch-off
  // Limitation: the B pins use the same trigger as the A pin.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pulse_q <= 1'b0;
    end else if (on_rise) begin
      pulse_q <= 1'b1; // R4
    end else if (hit || !on_now) begin
      pulse_q <= 1'b0;
    end
  end

  // Capture input history; pins are synchronous to ref_clk already
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cap_prev_q <= 1'b0;
    end else begin
      cap_prev_q <= cap_in;
    end
  end

  // Capture edge selection
  always_comb begin
    cap_evt = 1'b0;
    if (mode == MODE_CAP && on_now) begin
      unique case (pin_fn) // R5
        CAP_RISE: cap_evt = cap_in && !cap_prev_q;
        CAP_FALL: cap_evt = !cap_in && cap_prev_q;
        CAP_BOTH: cap_evt = cap_in != cap_prev_q;
        CAP_OFF: cap_evt = 1'b0;
      endcase
    end
  end

  // Level before inversion; init_lvl is the active level in PWM modes
  always_comb begin
    raw = lvl_q;
    if (mode == MODE_PWM) begin
      unique case (pin_fn) // R4
        FN_INACT: raw = ~init_lvl;
        FN_ACT: raw = init_lvl;
        FN_PWM: raw = (cnt < cmp) ? init_lvl : ~init_lvl;
        FN_PULSE: raw = pulse_q ? init_lvl : ~init_lvl;
      endcase
    end
  end

  // Registered pin drive; timer mode and capture mode leave the pin alone
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else if (mode == MODE_TMR || mode == MODE_CAP) begin
      pin_q <= 1'b0; // R10
      pin_oe_q <= 1'b0;
    end else begin
      pin_q <= raw ^ invert; // R10
      pin_oe_q <= 1'b1;
    end
  end

  a_cmp_drive_low: assert property (@(posedge ref_clk) // R3
    disable iff (!rstn) mode == MODE_CMP && hit && !on_rise &&
    pin_fn == FN_LOW |=> lvl_q == 1'b0 ##1 pin_q == $past(invert))
    else $error("compare low did not drive pin low");

  a_pwm_inactive: assert property (@(posedge ref_clk) // R4
    disable iff (!rstn) mode == MODE_PWM && pin_fn == FN_INACT
    |=> pin_q == (~$past(init_lvl) ^ $past(invert)) && pin_oe_q)
    else $error("pwm inactive level wrong");

  a_tmr_no_drive: assert property (@(posedge ref_clk) // R10
    disable iff (!rstn) mode == MODE_TMR |=> !pin_oe_q && !pin_q)
    else $error("timer mode drives the pin");

endmodule : etc_chan_out

/* File: etc_top.sv */
// Enhanced timer compare unit: APB registers, 10-bit counter, three
// comparators, match flags and the A and B output pins.
// Assumes one 100 MHz clock, synchronous pins and a zero-wait APB master.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
// Behaviour
// R1: B mode field picks compare/capture/PWM/timer
// R2: Software stops timer before mode changes
// R3: Compare match holds, clears, sets, toggles pins
// R4: PWM code: inactive, active, PWM, single pulse
// R5: Capture on rise, fall, both, or off
// R6: Initial level bit sets start/active level
// R7: Match to the initial level shows nothing
// R8: Timer switch-on restores initial pin level
// R9: Software changes PWM pin codes only stopped
// R10: Invert bit inverts pins except timer mode
// R11: Alignment: edge, centre up, down, both
// R12: Counter readable as low and high bytes
// R13: Compare values A, B: 10-bit read/write
// R14: Software sets both channels to one mode
// R15: Compare mode clears by overflow, A or P
// R16: Clear-source low: P or overflow clears
// R17: Clear-source high: A clears, no P flag
// R18: Only A and B matches move pins
// R19: A code drives A pin, B all three
// R20: Software disables pin control in timer mode
// R21: Switch-on zeroes counter, switch-off holds it
// R22: Period field compares counter bits 9 to 7
// R23: Pause bit freezes and resumes the counter
// R24: Each match sets its flag once
module etc_top #(
  parameter int unsigned TICK_DIV = etc_pkg::TICK_DIV
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [etc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cap_a_in,
  input wire logic cap_b_in,
  output logic out_pin_a,
  output logic out_pin_a_oe,
  output logic out_pin_b0,
  output logic out_pin_b0_oe,
  output logic out_pin_b1,
  output logic out_pin_b1_oe,
  output logic out_pin_b2,
  output logic out_pin_b2_oe
);
  import etc_pkg::*;

  // A divider of zero has no meaning
  if (TICK_DIV < 1 || TICK_DIV > 256) begin : g_bad_div
    $error("TICK_DIV must lie between 1 and 256");
  end

  // Register state
  logic [7:0] ctrl0_q; // Pause, on and period field
  logic [7:0] cha_q; // channel_a_control, direction bit unused here
  logic [7:0] chb_q; // channel_b_control
  logic [9:0] cmpa_q; // compare_value_a
  logic [9:0] cmpb_q; // compare_value_b
  logic [2:0] flag_q; // P, B, A match flags
  logic [31:0] prdata_q; // Read data taken in the setup cycle

  // Counter state
  logic [9:0] cnt_q;
  etc_dir_type dir_q;
  logic [7:0] div_q; // Timer clock divider
  logic on_prev_q; // On bit one clock ago, for edge detection

  // Decoded fields
  logic timer_on_bit;
  logic count_pause_bit;
  logic [2:0] period_field;
  etc_mode_type chan_a_mode_sel;
  etc_mode_type chan_b_mode_sel;
  logic clear_source_select;
  logic [1:0] pwm_alignment_sel;

  // Internal events
  logic tick; // One-cycle timer clock enable
  logic run; // Counter advances this cycle
  logic on_rise;
  logic centre;
  logic dir_ok;
  logic [9:0] top;
  logic hit_a_cmp;
  logic hit_b_cmp;
  logic hit_a;
  logic hit_b;
  logic hit_p;
  logic cap_a_evt;
  logic cap_b_evt;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [31:0] rd_word;
  logic pin_b;
  logic pin_b_oe;

  assign timer_on_bit = ctrl0_q[CTRL0_ON];
  assign count_pause_bit = ctrl0_q[CTRL0_PAUSE];
  assign period_field = ctrl0_q[CTRL0_PER_LSB +: PER_W];
  assign chan_a_mode_sel = etc_mode_type'(cha_q[CH_MODE_LSB +: 2]);
  assign chan_b_mode_sel = etc_mode_type'(chb_q[CH_MODE_LSB +: 2]); // R1
  assign clear_source_select = cha_q[CHA_CLR];
  assign pwm_alignment_sel = chb_q[CHB_ALIGN_LSB +: 2];

  // APB decode: zero wait states, error only for unmapped addresses
  always_comb begin
    unique case (paddr)
      OFF_CTRL0, OFF_CHA, OFF_CHB, OFF_CNT_LO, OFF_CNT_HI, OFF_CMPA_LO,
      OFF_CMPA_HI, OFF_CMPB_LO, OFF_CMPB_HI, OFF_FLAGS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign prdata = prdata_q;

  // Read multiplexer; counter and compare values read as byte pairs
  always_comb begin
    rd_word = 32'h00000000;
    unique case (paddr)
      OFF_CTRL0: rd_word = {24'h000000, ctrl0_q};
      OFF_CHA: rd_word = {24'h000000, cha_q[7:2], dir_q, cha_q[CHA_CLR]};
      OFF_CHB: rd_word = {24'h000000, chb_q};
      OFF_CNT_LO: rd_word = etc_lo_word(cnt_q); // R12
      OFF_CNT_HI: rd_word = etc_hi_word(cnt_q); // R12
      OFF_CMPA_LO: rd_word = etc_lo_word(cmpa_q); // R13
      OFF_CMPA_HI: rd_word = etc_hi_word(cmpa_q); // R13
      OFF_CMPB_LO: rd_word = etc_lo_word(cmpb_q); // R13
      OFF_CMPB_HI: rd_word = etc_hi_word(cmpb_q); // R13
      OFF_FLAGS: rd_word = {29'h00000000, flag_q};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read data is taken in the setup cycle so that it leaves a flip-flop
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prdata_q <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_q <= rd_word;
    end
  end

  // Control registers; the direction bit in channel A is read only
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl0_q <= CTRL_RST;
      cha_q <= CTRL_RST;
      chb_q <= CTRL_RST;
    end else if (wr_en) begin
      if (paddr == OFF_CTRL0) begin
        ctrl0_q <= pwdata[7:0];
      end
      if (paddr == OFF_CHA) begin
        cha_q <= {pwdata[7:2], 1'b0, pwdata[CHA_CLR]};
      end
      if (paddr == OFF_CHB) begin
        chb_q <= pwdata[7:0];
      end
    end
  end

  // Compare values: byte writes, or the counter latched on a capture edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cmpa_q <= CMP_RST;
      cmpb_q <= CMP_RST;
    end else begin
      if (cap_a_evt) begin
        cmpa_q <= cnt_q; // R5
      end else if (wr_en && paddr == OFF_CMPA_LO) begin
        cmpa_q[7:0] <= pwdata[7:0]; // R13
      end else if (wr_en && paddr == OFF_CMPA_HI) begin
        cmpa_q[9:8] <= pwdata[1:0]; // R13
      end
      if (cap_b_evt) begin
        cmpb_q <= cnt_q; // R5
      end else if (wr_en && paddr == OFF_CMPB_LO) begin
        cmpb_q[7:0] <= pwdata[7:0]; // R13
      end else if (wr_en && paddr == OFF_CMPB_HI) begin
        cmpb_q[9:8] <= pwdata[1:0]; // R13
      end
    end
  end

  // Divider for the timer clock enable
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(TICK_DIV - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign tick = div_q == 8'(TICK_DIV - 1);

  // Switch-on edge of the timer
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= timer_on_bit;
    end
  end

  assign on_rise = timer_on_bit && !on_prev_q;
  assign run = timer_on_bit && !count_pause_bit && tick && !on_rise; // R23
  assign centre = chan_b_mode_sel == MODE_PWM &&
    pwm_alignment_sel != ALIGN_EDGE; // R11

  // Turn-round point: A value, or the top of the last 128-count period;
  // a period field of zero wraps to 1023, the natural overflow
  assign top = clear_source_select ? cmpa_q :
    {3'(period_field - 3'd1), 7'h7f}; // R22

  // Counter: edge mode clears at the top, centre mode counts back down
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_q <= 10'h000;
      dir_q <= DIR_UP;
    end else if (on_rise) begin
      cnt_q <= 10'h000; // R21
      dir_q <= DIR_UP;
    end else if (run) begin
      if (!centre) begin
        dir_q <= DIR_UP;
        cnt_q <= (cnt_q == top) ? 10'h000 : cnt_q + 10'h001; // R15
      end else if (dir_q == DIR_UP) begin
        if (cnt_q >= top) begin
          dir_q <= DIR_DOWN;
          cnt_q <= (cnt_q == 10'h000) ? cnt_q : cnt_q - 10'h001;
        end else begin
          cnt_q <= cnt_q + 10'h001;
        end
      end else if (cnt_q == 10'h000) begin
        dir_q <= DIR_UP;
        cnt_q <= (top == 10'h000) ? cnt_q : 10'h001;
      end else begin
        cnt_q <= cnt_q - 10'h001;
      end
    end
  end

  // Centre-aligned matches count only in the chosen direction
  always_comb begin
    unique case (pwm_alignment_sel) // R11
      ALIGN_EDGE: dir_ok = 1'b1;
      ALIGN_UP: dir_ok = !centre || dir_q == DIR_UP;
      ALIGN_DN: dir_ok = !centre || dir_q == DIR_DOWN;
      ALIGN_BOTH: dir_ok = 1'b1;
    endcase
  end

  // Comparators, evaluated once per timer clock
  assign hit_a_cmp = run && cnt_q == cmpa_q && dir_ok &&
    chan_a_mode_sel != MODE_CAP; // R24
  assign hit_b_cmp = run && cnt_q == cmpb_q && dir_ok &&
    chan_b_mode_sel != MODE_CAP; // R24
  assign hit_a = hit_a_cmp || cap_a_evt;
  assign hit_b = hit_b_cmp || cap_b_evt;
  assign hit_p = run && !clear_source_select && // R17
    (centre ? (dir_q == DIR_DOWN && cnt_q == 10'h000) :
     cnt_q == top); // R16

  // Match flags; software writes ones to clear, a new match wins
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flag_q <= 3'h0;
    end else begin
      flag_q <= (flag_q & ~((wr_en && paddr == OFF_FLAGS) ?
        pwdata[2:0] : 3'h0)) | {hit_p, hit_b, hit_a}; // R24
    end
  end

  // Channel A output; only its own match moves it, never P
  etc_chan_out u_chan_a (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .mode(chan_a_mode_sel),
    .pin_fn(cha_q[CH_FN_LSB +: 2]), // R19
    .init_lvl(cha_q[CH_INIT]), // R6
    .invert(cha_q[CH_INV]),
    .on_rise(on_rise),
    .on_now(timer_on_bit),
    .hit(hit_a_cmp), // R18
    .cnt(cnt_q),
    .cmp(cmpa_q),
    .cap_in(cap_a_in),
    .cap_evt(cap_a_evt),
    .pin_q(out_pin_a),
    .pin_oe_q(out_pin_a_oe)
  );

  // Channel B output; one stage drives all three B pins together
  etc_chan_out u_chan_b (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .mode(chan_b_mode_sel),
    .pin_fn(chb_q[CH_FN_LSB +: 2]), // R19
    .init_lvl(chb_q[CH_INIT]), // R6
    .invert(chb_q[CH_INV]), // R10
    .on_rise(on_rise),
    .on_now(timer_on_bit),
    .hit(hit_b_cmp), // R18
    .cnt(cnt_q),
    .cmp(cmpb_q),
    .cap_in(cap_b_in),
    .cap_evt(cap_b_evt),
    .pin_q(pin_b),
    .pin_oe_q(pin_b_oe)
  );

  // The three B pins share one level and one enable
  assign out_pin_b0 = pin_b; // R19
  assign out_pin_b1 = pin_b;
  assign out_pin_b2 = pin_b;
  assign out_pin_b0_oe = pin_b_oe;
  assign out_pin_b1_oe = pin_b_oe;
  assign out_pin_b2_oe = pin_b_oe;

  a_on_rise_zero: assert property (@(posedge ref_clk) // R21
    disable iff (!rstn) timer_on_bit && !on_prev_q |=> cnt_q == 10'h000)
    else $error("counter not zeroed at switch-on");

  a_off_holds: assert property (@(posedge ref_clk) // R21
    disable iff (!rstn) !timer_on_bit && !on_prev_q |=> $stable(cnt_q))
    else $error("counter moved while switched off");

  a_pause_holds: assert property (@(posedge ref_clk) // R23
    disable iff (!rstn) count_pause_bit && on_prev_q
    |=> cnt_q == $past(cnt_q))
    else $error("counter moved while paused");

  // Watches the flag itself, so a P set through any path is caught
  a_no_p_flag: assert property (@(posedge ref_clk) // R17
    disable iff (!rstn) clear_source_select && !flag_q[FLAG_P]
    |=> !flag_q[FLAG_P])
    else $error("P flag raised with clear-source high");

  a_a_clears: assert property (@(posedge ref_clk) // R17
    disable iff (!rstn) clear_source_select && !centre && hit_a_cmp
    |=> cnt_q == 10'h000 && flag_q[FLAG_A])
    else $error("A match did not clear the counter");

  a_overflow_p: assert property (@(posedge ref_clk) // R16
    disable iff (!rstn) run && !centre && !clear_source_select &&
    period_field == 3'h0 && cnt_q == 10'h3ff
    |=> cnt_q == 10'h000 && flag_q[FLAG_P])
    else $error("overflow did not clear and flag");

  a_hi_byte_zero: assert property (@(posedge ref_clk) // R12
    disable iff (!rstn) rd_setup && paddr == OFF_CNT_HI
    |=> prdata[31:2] == '0 && prdata[1:0] == $past(cnt_q[9:8]))
    else $error("counter high byte read wrong");

  a_b_flag_set: assert property (@(posedge ref_clk) // R24
    disable iff (!rstn) hit_b |=> flag_q[FLAG_B])
    else $error("B match lost its flag");

endmodule : etc_top

/* File: etc_pin_model.sv */
// Board side of the timer pins: pull-down line levels and a capture
// edge source. Assumes the bench requests edges one clock at a time.
`timescale 1ns/1ps
module etc_pin_model (
  input wire logic ref_clk,
  input wire logic [3:0] pin,
  input wire logic [3:0] pin_oe,
  input wire logic [1:0] edge_req,
  output logic [3:0] line,
  output logic cap_a_in,
  output logic cap_b_in
);
  // Released pins fall to the pull-down, never keep the last level
  assign line = pin & pin_oe;
  // A request raises the input for one clock: one rising edge each
  always_ff @(posedge ref_clk) begin
    cap_a_in <= edge_req[0];
    cap_b_in <= edge_req[1];
  end
endmodule : etc_pin_model

/* File: tb_top.sv */
// Self-checking bench of the timer compare unit over APB.
// Assumes TICK_DIV of 1, so one counter step per clock.
`timescale 1ns/1ps
module tb_top;
  import etc_pkg::*;
  // One register row: address, write data, readback, error
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } etc_row_type;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, e;
  logic cap_a_in, cap_b_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic [3:0] pin, oe, line;
  logic [1:0] edge_req;
  int bad_count, comparisons;
  etc_row_type rows [6];
  logic [7:0] cfg [4];
  logic [7:0] stops [2];
  logic [7:0] bfn [3];

  etc_top #(.TICK_DIV(1)) uut (.ref_clk, .rstn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .cap_a_in, .cap_b_in,
    .out_pin_a(pin[0]), .out_pin_a_oe(oe[0]), .out_pin_b0(pin[1]),
    .out_pin_b0_oe(oe[1]), .out_pin_b1(pin[2]), .out_pin_b1_oe(oe[2]),
    .out_pin_b2(pin[3]), .out_pin_b2_oe(oe[3]));
  etc_pin_model board (.ref_clk, .pin, .pin_oe(oe), .edge_req, .line,
    .cap_a_in, .cap_b_in);

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, entered right after an edge; holds until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt

  task finish_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Hang guard, well past the two thousand or so cycles of the run
  initial begin
    wt(8000);
    bad_count++;
    finish_test;
  end

  initial begin
    bad_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    edge_req = 2'b00;
    rows[0] = '{OFF_CMPA_LO, 32'h1ab, 32'hab, 1'b0};
    rows[1] = '{OFF_CMPA_HI, 32'hff, 32'h3, 1'b0};
    rows[2] = '{OFF_CMPB_HI, 32'hfe, 32'h2, 1'b0};
    rows[3] = '{OFF_CNT_LO, 32'h55, 32'h0, 1'b0};
    rows[4] = '{OFF_CHB, 32'h3c, 32'h3c, 1'b0};
    rows[5] = '{8'h40, 32'hff, 32'h0, 1'b1};
    // Capture, timer, PWM inactive, PWM active; same mode on both
    cfg = '{8'h40, 8'hc0, 8'h88, 8'h98};
    stops = '{8'h89, 8'h01};
    // B codes: compare low, PWM waveform, single pulse; all active high
    bfn = '{8'h18, 8'ha8, 8'hb8};
    wt(12);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // Reset values of all timer registers except the flag register
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(r, 32'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk(e, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      chk(r, rows[i].x);
    end
    // Compare mode: A sets high at 3, B toggles at 5, period 128
    apb(1'b1, OFF_CMPA_LO, 32'h3);
    apb(1'b1, OFF_CMPA_HI, 32'h0);
    apb(1'b1, OFF_CMPB_LO, 32'h5);
    apb(1'b1, OFF_CMPB_HI, 32'h0);
    apb(1'b1, OFF_CHA, 32'h20);
    apb(1'b1, OFF_CHB, 32'h30);
    apb(1'b1, OFF_CTRL0, 32'h09);
    wt(20);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(r, 32'h3);
    chk(line, 4'hf);
    apb(1'b1, OFF_FLAGS, 32'h7);
    wt(130);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(r, 32'h7);
    chk(line, 4'h1);
    // Pause, then switch-off: counter must hold its value
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFF_CTRL0, {24'h0, stops[i]});
      apb(1'b0, OFF_CNT_LO, 32'h0);
      v = r;
      wt(5);
      apb(1'b0, OFF_CNT_LO, 32'h0);
      chk(r, v);
      apb(1'b1, OFF_CTRL0, 32'h09);
    end
    // Mode bits change only with the timer off
    apb(1'b1, OFF_CTRL0, 32'h01);
    apb(1'b1, OFF_CHA, 32'h00);
    apb(1'b1, OFF_CTRL0, 32'h09);
    wt(20);
    chk(line[0], 1'b0);
    apb(1'b1, OFF_CTRL0, 32'h01);
    apb(1'b1, OFF_CHA, 32'h28);
    apb(1'b1, OFF_CHB, 32'h04);
    apb(1'b1, OFF_CTRL0, 32'h09);
    wt(20);
    chk(line, 4'hf);
    // Clear on A at 200, above the P point at 127: no P flag
    apb(1'b1, OFF_CTRL0, 32'h01);
    apb(1'b1, OFF_CHA, 32'h01);
    apb(1'b1, OFF_CMPA_LO, 32'hc8);
    apb(1'b1, OFF_FLAGS, 32'h7);
    apb(1'b1, OFF_CTRL0, 32'h09);
    wt(450);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(r, 32'h3);
    apb(1'b0, OFF_CNT_LO, 32'h0);
    chk(r <= 32'hc8, 1'b1);
    // B pins high early in the period, low once the count passes 5
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_CTRL0, 32'h01);
      apb(1'b1, OFF_CHA, i ? 32'h81 : 32'h01);
      apb(1'b1, OFF_CHB, {24'h0, bfn[i]});
      apb(1'b1, OFF_CTRL0, 32'h09);
      wt(3);
      chk(line[3:1], 3'h7);
      wt(10);
      chk(line[3:1], 3'h0);
    end
    // Period field zero: only the full 1024-count overflow raises P
    apb(1'b1, OFF_CTRL0, 32'h01);
    apb(1'b1, OFF_CHA, 32'h00);
    apb(1'b1, OFF_CHB, 32'h00);
    apb(1'b1, OFF_FLAGS, 32'h7);
    apb(1'b1, OFF_CTRL0, 32'h08);
    wt(1010);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(r & 32'h4, 32'h0);
    wt(20);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(r & 32'h4, 32'h4);
    // Pins per mode; PWM pins are only recoded while stopped
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_CTRL0, 32'h01);
      apb(1'b1, OFF_CHA, {24'h0, cfg[i]});
      apb(1'b1, OFF_CHB, {24'h0, cfg[i]});
      apb(1'b1, OFF_CTRL0, 32'h09);
      wt(4);
      chk(line, {4{i == 3}});
      chk(oe, {4{i > 1}});
    end
    // Capture on rise, fall and both edges, then with capture disabled
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, OFF_CTRL0, 32'h01);
      apb(1'b1, OFF_CHA, 32'h40);
      apb(1'b1, OFF_CHB, 32'(64 + 16 * j));
      apb(1'b1, OFF_FLAGS, 32'h7);
      apb(1'b1, OFF_CTRL0, 32'h09);
      wt(10);
      edge_req <= 2'b10;
      @(posedge ref_clk);
      edge_req <= 2'b00;
      wt(4);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk(r & 32'h2, j < 3 ? 32'h2 : 32'h0);
    end
    finish_test;
  end
endmodule : tb_top
